// ---- verilog/wrag_addr_gen.sv ----
// working register pointers, address resolution and set/bank routing
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - addresses below C0H pass unchanged in register, indirect and indexed modes, usable right after reset.
// - reset loads first pointer with C0H and second pointer with C8H.
// - the pointers are the set 1 registers at D6H and D7H.
// - pointers change only by set-pointer instruction or a load writing them.
// - working register addresses never land in set 2; they stay in set 1.
// - upper 64 locations reach set 2 only in indirect or indexed modes.
// - register mode operands at C0H and above decode to set 1.
// - pair operands use an even address, low byte at the next odd one.
// - bit 3 of a 4-bit field picks first (0) or second (1) pointer.
// - address is pointer's top five bits joined to the field's low three.
// - register operand with upper nibble 1100B is a working register access.
// - upper half of set 1 has two banks, bank 0 after reset.
module wrag_addr_gen (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire wrag_pkg::wrag_mode_t req_mode,
    input wire logic [7:0] req_operand,
    input wire logic req_pair,
    input wire logic req_write,
    input wire logic [7:0] req_wdata,
    input wire logic set_pointer_valid,
    input wire wrag_pkg::wrag_target_t set_pointer_target,
    input wire logic [7:0] set_pointer_value,
    input wire logic bank_zero_select,
    input wire logic bank_one_select,
    output logic out_valid,
    output logic [7:0] out_addr,
    output logic [7:0] out_pair_addr,
    output logic out_set2,
    output logic out_bank1,
    output logic out_working,
    output logic out_ptr_hit,
    output logic [7:0] out_rdata,
    output logic [7:0] first_slice_pointer,
    output logic [7:0] second_slice_pointer,
    output logic bank_select
);

    wrag_pkg::wrag_state_t st;
    wrag_pkg::wrag_state_t next_st;
    logic [7:0] work_addr;
    logic working;
    logic [7:0] eff_addr;
    logic upper_set2;
    logic load_first;
    logic load_second;

    // slice address from the low nibble of the operand
    wrag_slice_addr u_slice (
        .first_slice_pointer(st.first_slice_pointer),
        .second_slice_pointer(st.second_slice_pointer),
        .work_nibble(req_operand[3:0]),
        .work_addr(work_addr)
    );

    // working access: explicit 4-bit field, or register operand escape
    // the escape hides C0H-CFH from direct register addressing
    assign working = (req_mode == wrag_pkg::mode_working4)
        || (req_mode == wrag_pkg::mode_register
            && req_operand[7:4] == wrag_pkg::escape_nibble);

    // only indirect and indexed modes see set 2 in the upper 64 bytes
    assign upper_set2 = !working
        && (req_mode == wrag_pkg::mode_indirect || req_mode == wrag_pkg::mode_indexed)
        && (req_operand >= wrag_pkg::upper_base);

    // pair access forces the even register
    always_comb begin
        eff_addr = working ? work_addr : req_operand;
        if (req_pair) begin
            eff_addr[wrag_pkg::pair_bit] = 1'b0;
        end
    end

    // load instruction hitting a pointer location in set 1
    assign load_first = req_valid && req_write && !upper_set2
        && eff_addr == wrag_pkg::first_ptr_offset;
    assign load_second = req_valid && req_write && !upper_set2
        && eff_addr == wrag_pkg::second_ptr_offset;

    // next state; set-pointer wins over a load in the same cycle
    always_comb begin
        next_st = st;
        next_st.out_valid = req_valid;
        next_st.out_addr = eff_addr;
        next_st.out_pair_addr = eff_addr | 8'h01;
        next_st.out_set2 = upper_set2;
        next_st.out_bank1 = !upper_set2 && eff_addr >= wrag_pkg::bank_base && st.bank;
        next_st.out_working = working;
        next_st.out_ptr_hit = 1'b0;
        next_st.out_rdata = 8'h00;
        // readback of a pointer register shows the value before any update
        if (req_valid && !req_write && !upper_set2) begin
            if (eff_addr == wrag_pkg::first_ptr_offset) begin
                next_st.out_ptr_hit = 1'b1;
                next_st.out_rdata = st.first_slice_pointer;
            end else if (eff_addr == wrag_pkg::second_ptr_offset) begin
                next_st.out_ptr_hit = 1'b1;
                next_st.out_rdata = st.second_slice_pointer;
            end
        end
        if (!req_valid) begin
            next_st.out_addr = 8'h00;
            next_st.out_pair_addr = 8'h00;
            next_st.out_set2 = 1'b0;
            next_st.out_bank1 = 1'b0;
            next_st.out_working = 1'b0;
        end
        // pointer writes
        if (load_first) begin
            next_st.first_slice_pointer = req_wdata;
        end
        if (load_second) begin
            next_st.second_slice_pointer = req_wdata;
        end
        if (set_pointer_valid) begin
            unique case (set_pointer_target)
                wrag_pkg::target_both: begin
                    next_st.first_slice_pointer = set_pointer_value;
                    next_st.second_slice_pointer = set_pointer_value + wrag_pkg::slice_step;
                end
                wrag_pkg::target_first: begin
                    next_st.first_slice_pointer = set_pointer_value;
                end
                wrag_pkg::target_second: begin
                    next_st.second_slice_pointer = set_pointer_value;
                end
                wrag_pkg::target_none: begin
                end
            endcase
        end
        // bank select; bank one wins if both arrive together
        if (bank_zero_select) begin
            next_st.bank = 1'b0;
        end
        if (bank_one_select) begin
            next_st.bank = 1'b1;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.first_slice_pointer <= wrag_pkg::first_ptr_reset;
            st.second_slice_pointer <= wrag_pkg::second_ptr_reset;
            st.bank <= wrag_pkg::bank_reset;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign out_valid = st.out_valid;
    assign out_addr = st.out_addr;
    assign out_pair_addr = st.out_pair_addr;
    assign out_set2 = st.out_set2;
    assign out_bank1 = st.out_bank1;
    assign out_working = st.out_working;
    assign out_ptr_hit = st.out_ptr_hit;
    assign out_rdata = st.out_rdata;
    assign first_slice_pointer = st.first_slice_pointer;
    assign second_slice_pointer = st.second_slice_pointer;
    assign bank_select = st.bank;

    // checks on the registered answers
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // reset values seen on the first edge out of reset; the default disable would hide any srst antecedent
    a_reset_first_ptr: assert property ($fell(srst) |-> first_slice_pointer == wrag_pkg::first_ptr_reset)
        else $error("first pointer not c0 after reset");
    a_reset_second_ptr: assert property ($fell(srst) |-> second_slice_pointer == wrag_pkg::second_ptr_reset)
        else $error("second pointer not c8 after reset");
    a_reset_bank: assert property ($fell(srst) |-> bank_select == wrag_pkg::bank_reset)
        else $error("bank not zero after reset");

    a_ptr_hold: assert property (!set_pointer_valid && !load_first && !load_second
        |=> $stable(first_slice_pointer) && $stable(second_slice_pointer))
        else $error("pointer changed without a write");

    a_ptr_load: assert property (load_first && !set_pointer_valid
        |=> first_slice_pointer == $past(req_wdata))
        else $error("load to d6 did not reach first pointer");

    a_prime_pass: assert property (req_valid && !working && !req_pair && req_operand < 8'hc0
        |=> out_valid && out_addr == $past(req_operand) && !out_set2)
        else $error("prime area address altered");

    a_working_set1: assert property (out_valid && out_working |-> !out_set2)
        else $error("working access routed to set 2");

    a_set2_mode: assert property (out_set2 |-> out_addr >= 8'hc0
        && ($past(req_mode) == wrag_pkg::mode_indirect || $past(req_mode) == wrag_pkg::mode_indexed))
        else $error("set 2 reached by wrong mode");

    a_register_set1: assert property (req_valid && req_mode == wrag_pkg::mode_register
        |=> !out_set2)
        else $error("register mode routed to set 2");

    a_pair_even: assert property (req_valid && req_pair
        |=> !out_addr[0] && out_pair_addr == out_addr + 8'h01)
        else $error("pair not even or odd partner wrong");

    a_work_form: assert property (req_valid && req_mode == wrag_pkg::mode_working4 && !req_pair
        |=> out_addr == {($past(req_operand[3]) ? $past(second_slice_pointer[7:3])
            : $past(first_slice_pointer[7:3])), $past(req_operand[2:0])})
        else $error("working address formed wrongly");

    // a pointer may legally hold a slice near 00H, so the whole resolved address is compared
    a_escape_decode: assert property (req_valid && req_mode == wrag_pkg::mode_register
        && req_operand[7:4] == 4'hc |=> out_working
        && out_addr[7:3] == ($past(req_operand[3]) ? $past(second_slice_pointer[7:3])
            : $past(first_slice_pointer[7:3]))
        && out_addr[2:1] == $past(req_operand[2:1])
        && out_addr[0] == ($past(req_operand[0]) && !$past(req_pair)))
        else $error("escape operand not working access");

    c_escape: cover property (req_valid && req_mode == wrag_pkg::mode_register && req_operand[7:4] == 4'hc);
    c_set2: cover property (out_set2);
    c_pair: cover property (req_valid && req_pair ##1 out_valid);
    c_set_ptr: cover property (set_pointer_valid && set_pointer_target == wrag_pkg::target_both);

endmodule : wrag_addr_gen

`default_nettype wire

// ---- verilog/wrag_pkg.sv ----
// constants and types shared by the working register address generator
package wrag_pkg;

    // pointer register locations in set 1
    localparam logic [7:0] first_ptr_offset = 8'hd6;
    localparam logic [7:0] second_ptr_offset = 8'hd7;

    // pointer values after reset: the common working area
    localparam logic [7:0] first_ptr_reset = 8'hc0;
    localparam logic [7:0] second_ptr_reset = 8'hc8;

    // bank select after reset
    localparam logic bank_reset = 1'b0;

    // region boundaries
    localparam logic [7:0] upper_base = 8'hc0;
    localparam logic [7:0] bank_base = 8'he0;

    // upper nibble that marks an 8-bit working register operand
    localparam logic [3:0] escape_nibble = 4'hc;

    // step between the two slices when both pointers are set together
    localparam logic [7:0] slice_step = 8'h08;

    // field positions
    localparam int pair_bit = 0;
    localparam int ptr_sel_bit = 3;

    // cycles from an accepted request to its registered answer
    localparam int answer_latency = 1;

    // addressing modes as decoded by the instruction logic
    typedef enum logic [1:0] {
        mode_register,
        mode_indirect,
        mode_indexed,
        mode_working4
    } wrag_mode_t;

    // targets of the set-pointer instruction
    typedef enum logic [1:0] {
        target_both,
        target_first,
        target_second,
        target_none
    } wrag_target_t;

    // complete state of the address generator
    typedef struct packed {
        logic [7:0] first_slice_pointer;
        logic [7:0] second_slice_pointer;
        logic bank;
        logic out_valid;
        logic [7:0] out_addr;
        logic [7:0] out_pair_addr;
        logic out_set2;
        logic out_bank1;
        logic out_working;
        logic out_ptr_hit;
        logic [7:0] out_rdata;
    } wrag_state_t;

endpackage : wrag_pkg

// ---- verilog/wrag_slice_addr.sv ----
// forms a full register address from a 4-bit working register field
`timescale 1ns/10ps
`default_nettype none

module wrag_slice_addr (
    input wire logic [7:0] first_slice_pointer,
    input wire logic [7:0] second_slice_pointer,
    input wire logic [3:0] work_nibble,
    output logic [7:0] work_addr
);

    // pointer chosen by the high bit, its five top bits joined to the low three
    assign work_addr = work_nibble[wrag_pkg::ptr_sel_bit]
        ? {second_slice_pointer[7:3], work_nibble[2:0]}
        : {first_slice_pointer[7:3], work_nibble[2:0]};

endmodule : wrag_slice_addr

`default_nettype wire

// ---- verif/wrag_cpu_model.sv ----
// decoder stand-in driving operand and pointer requests
`timescale 1ns/10ps
`default_nettype none

module wrag_cpu_model (
    output logic req_valid,
    output var wrag_pkg::wrag_mode_t req_mode,
    output logic [7:0] req_operand,
    output logic req_pair,
    output logic req_write,
    output logic [7:0] req_wdata,
    output logic set_pointer_valid,
    output var wrag_pkg::wrag_target_t set_pointer_target,
    output logic [7:0] set_pointer_value,
    output logic bank_zero_select,
    output logic bank_one_select
);
    // one decoded instruction; idle cycles carry junk fields so nothing stale looks valid
    task automatic drive(input logic rv, input logic [1:0] m, input logic [7:0] a, input logic pr,
                         input logic wr, input logic [7:0] wd, input logic sv, input logic [1:0] tg,
                         input logic [7:0] v, input logic b0, input logic b1);
        req_valid = rv;
        req_mode = wrag_pkg::wrag_mode_t'(m);
        req_operand = a;
        req_pair = pr;
        req_write = wr;
        req_wdata = wd;
        set_pointer_valid = sv;
        set_pointer_target = wrag_pkg::wrag_target_t'(tg);
        set_pointer_value = v;
        bank_zero_select = b0;
        bank_one_select = b1;
    endtask : drive
endmodule : wrag_cpu_model
`default_nettype wire

// ---- verif/working_register_address_gen_test.sv ----
// self-checking bench for the working register address generator
`timescale 1ns/10ps
`default_nettype none

module working_register_address_gen_test;
    logic clk, srst, req_valid, req_pair, req_write, set_pointer_valid, bank_zero_select, bank_one_select;
    wrag_pkg::wrag_mode_t req_mode;
    wrag_pkg::wrag_target_t set_pointer_target;
    logic [7:0] req_operand, req_wdata, set_pointer_value, out_addr, out_pair_addr, out_rdata;
    logic [7:0] first_slice_pointer, second_slice_pointer, fp, sp;
    logic out_valid, out_set2, out_bank1, out_working, out_ptr_hit, bank_select, bk;
    logic [31:0] r = 32'h00000015;
    int num_errors = 0;
    int num_checks = 0;

    wrag_addr_gen wrag_addr_gen_i (.clk, .srst, .req_valid, .req_mode, .req_operand, .req_pair, .req_write,
        .req_wdata, .set_pointer_valid, .set_pointer_target, .set_pointer_value, .bank_zero_select,
        .bank_one_select, .out_valid, .out_addr, .out_pair_addr, .out_set2, .out_bank1, .out_working,
        .out_ptr_hit, .out_rdata, .first_slice_pointer, .second_slice_pointer, .bank_select);
    wrag_cpu_model wrag_cpu_model_i (.req_valid, .req_mode, .req_operand, .req_pair, .req_write, .req_wdata,
        .set_pointer_valid, .set_pointer_target, .set_pointer_value, .bank_zero_select, .bank_one_select);

    // 4 ns core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // expected address from the bench's own pointer copy
    function automatic logic [7:0] exp_addr(input logic [1:0] m, input logic [7:0] op, input logic pr);
        logic [7:0] p, a;
        p = op[3] ? sp : fp;
        a = (m == 2'd3 || (m == 2'd0 && op[7:4] == 4'hc)) ? {p[7:3], op[2:0]} : op;
        return pr ? {a[7:1], 1'b0} : a;
    endfunction : exp_addr

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic idle();
        r = xs(r);
        wrag_cpu_model_i.drive(1'b0, r[1:0], r[9:2], r[10], r[11], r[19:12], 1'b0, r[21:20], r[31:24], 1'b0, 1'b0);
    endtask : idle

    // reset held n edges; pointers and bank must come back
    task automatic rst(input int n);
        srst = 1'b1;
        idle();
        repeat (n) @(posedge clk);
        #1;
        srst = 1'b0;
        fp = 8'hc0;
        sp = 8'hc8;
        bk = 1'b0;
        chk(8'(out_valid), 8'h00, "valid");
        chk(first_slice_pointer, fp, "ptr0");
        chk(second_slice_pointer, sp, "ptr1");
        chk(8'(bank_select), 8'(bk), "bank");
    endtask : rst

    // one request, answer checked one edge later, then the model moves on
    task automatic step(input logic [1:0] m, input logic [7:0] op, input logic pr, input logic wr,
                        input logic [7:0] wd, input logic sv, input logic [1:0] tg, input logic [7:0] v,
                        input logic b0, input logic b1);
        logic [7:0] a;
        logic s2, hit;
        a = exp_addr(m, op, pr);
        s2 = (m == 2'd1 || m == 2'd2) && op >= 8'hc0;
        hit = !wr && !s2 && a[7:1] == 7'h6b;
        wrag_cpu_model_i.drive(1'b1, m, op, pr, wr, wd, sv, tg, v, b0, b1);
        @(posedge clk);
        #1;
        chk(8'(out_valid), 8'h01, "valid");
        chk(out_addr, a, "addr");
        chk(out_pair_addr, a | 8'h01, "pair");
        chk(8'(out_set2), 8'(s2), "set2");
        chk(8'(out_bank1), 8'(bk && !s2 && a >= 8'he0), "bank1");
        chk(8'(out_working), 8'(m == 2'd3 || (m == 2'd0 && op[7:4] == 4'hc)), "work");
        chk(8'(out_ptr_hit), 8'(hit), "hit");
        chk(out_rdata, hit ? (a[0] ? sp : fp) : 8'h00, "rdata");
        if (wr && !s2 && a == 8'hd6) fp = wd;
        if (wr && !s2 && a == 8'hd7) sp = wd;
        // set-pointer applied last so it beats a same-cycle load
        if (sv && tg == 2'd0) sp = v + 8'h08;
        if (sv && tg < 2'd2) fp = v;
        if (sv && tg == 2'd2) sp = v;
        bk = b1 | (bk & !b0);
        chk(first_slice_pointer, fp, "ptr0");
        chk(second_slice_pointer, sp, "ptr1");
        chk(8'(bank_select), 8'(bk), "bank");
    endtask : step

    // cut a hung run short
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        results();
    end

    initial begin
        rst(10);
        $display("test reset done");
        step(2'd0, 8'hd6, 0, 0, 0, 0, 0, 0, 0, 0);
        step(2'd1, 8'h40, 0, 0, 0, 1, 2'd1, 8'h70, 0, 0);
        step(2'd3, 8'h06, 0, 0, 0, 0, 0, 0, 0, 0);
        step(2'd0, 8'hd7, 0, 1, 8'ha8, 0, 0, 0, 0, 0);
        step(2'd0, 8'hcb, 0, 0, 0, 0, 0, 0, 0, 0);
        step(2'd1, 8'hd7, 0, 1, 8'h11, 0, 0, 0, 0, 0);
        step(2'd2, 8'hd0, 0, 0, 0, 0, 0, 0, 0, 0);
        step(2'd0, 8'hd0, 0, 0, 0, 0, 0, 0, 0, 0);
        step(2'd0, 8'h8f, 1, 0, 0, 1, 2'd0, 8'hf0, 0, 0);
        step(2'd3, 8'h0d, 1, 0, 0, 0, 0, 0, 1, 1);
        step(2'd0, 8'he5, 0, 0, 0, 1, 2'd3, 8'h99, 0, 0);
        step(2'd1, 8'hf0, 0, 0, 0, 1, 2'd2, 8'h30, 1, 0);
        step(2'd0, 8'hd6, 0, 1, 8'h55, 1, 2'd1, 8'h20, 0, 0);
        step(2'd0, 8'he5, 0, 0, 0, 0, 0, 0, 0, 0);
        $display("test directed done");
        repeat (300) begin
            r = xs(r);
            step(r[1:0], r[9:2], r[10] & !r[11], r[11], r[19:12], r[20] & r[21], r[23:22], r[31:24],
                 r[24] & r[25], r[26] & r[27]);
        end
        idle();
        @(posedge clk);
        #1;
        chk(8'(out_valid), 8'h00, "idle");
        chk(out_addr, 8'h00, "idle addr");
        chk(out_pair_addr, 8'h00, "idle pair");
        $display("test random done");
        rst(2);
        step(2'd3, 8'h0b, 0, 0, 0, 0, 0, 0, 0, 0);
        $display("test midreset done");
        results();
    end
endmodule : working_register_address_gen_test
`default_nettype wire
